// *** tb/scir_ctrl_props.sv ***
`timescale 1ns/1ps
module scir_ctrl_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic dc_i,
  input wire logic ab_i,
  input wire logic intack_n_i,
  input wire logic irq_chain_enable_in_i,
  input wire logic a_rx_pop_o,
  input wire logic b_rx_pop_o,
  input wire logic int_oe_o,
  input wire logic irq_chain_enable_out_o,
  input wire logic int_rst_o
);
  default clocking dck @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_hw_rst_seen: assert property ((!rd_n_i && !wr_n_i) [*4] |-> int_rst_o)
    else $error("reset not seen with both strobes low");
  a_stretch_min: assert property (((!rd_n_i && !wr_n_i) [*4] ##1 (rd_n_i && wr_n_i) [*5])
    |-> int_rst_o) else $error("internal reset released too early");
  a_stretch_max: assert property (((!rd_n_i && !wr_n_i) [*4] ##1 (rd_n_i && wr_n_i) [*8])
    |-> !int_rst_o) else $error("internal reset held too long");
  a_pop_refused: assert property (int_rst_o |-> !(a_rx_pop_o || b_rx_pop_o))
    else $error("access taken during internal reset");
  a_rst_int_quiet: assert property ((int_rst_o && $past(int_rst_o)) |-> !int_oe_o)
    else $error("interrupt requested during reset");
  // Acknowledge pin is synced, so only a settled low is judged
  a_ack_quiet: assert property ((!intack_n_i) [*4] |-> !int_oe_o)
    else $error("interrupt requested during acknowledge");
  // Chain input is synced too, so it is judged once it has settled low
  a_chain_block: assert property ((!irq_chain_enable_in_i) [*3] |-> !int_oe_o
    && !irq_chain_enable_out_o) else $error("request with chain input low");
  a_pop_source: assert property ((a_rx_pop_o || b_rx_pop_o) |-> !rd_n_i && wr_n_i
    && dc_i && (a_rx_pop_o == ab_i)) else $error("pop without data read");
  a_pop_once: assert property (a_rx_pop_o |=> (!a_rx_pop_o) [*3])
    else $error("pop longer than one cycle");
endmodule

bind scir_ctrl scir_ctrl_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .dc_i(dc_i), .ab_i(ab_i), .intack_n_i(intack_n_i),
  .irq_chain_enable_in_i(irq_chain_enable_in_i), .a_rx_pop_o(a_rx_pop_o),
  .b_rx_pop_o(b_rx_pop_o), .int_oe_o(int_oe_o),
  .irq_chain_enable_out_o(irq_chain_enable_out_o), .int_rst_o(int_rst_o));

// *** tb/scir_host_bfm.sv ***
`timescale 1ns/1ps
module scir_host_bfm (
  input wire logic clk_i,
  input wire logic [7:0] data_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ce_n_o,
  output logic dc_o,
  output logic ab_o,
  output logic intack_n_o,
  output logic [7:0] wd_o
);
  initial begin
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ce_n_o = 1'b1;
    dc_o = 1'b0;
    ab_o = 1'b0;
    intack_n_o = 1'b1;
    wd_o = 8'h5A;
  end

  // Six cycles low covers the sync path and the four-cycle minimum
  task automatic access(input logic w, input logic d, input logic a, input logic [7:0] wd,
                        output logic [7:0] rd);
    @(negedge clk_i);
    dc_o = d;
    ab_o = a;
    wd_o = wd;
    ce_n_o = 1'b0;
    rd_n_o = w;
    wr_n_o = ~w;
    repeat (6) @(negedge clk_i);
    rd = data_o;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ce_n_o = 1'b1;
    // Released bus shows the inverse so a stale byte cannot pass
    wd_o = ~wd;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic ack();
    @(negedge clk_i);
    intack_n_o = 1'b0;
    repeat (3) @(negedge clk_i);
    rd_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    rd_n_o = 1'b1;
    repeat (3) @(negedge clk_i);
    intack_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask

  // Chip enable stays high: the reset must not depend on it
  task automatic pin_reset();
    @(negedge clk_i);
    rd_n_o = 1'b0;
    wr_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
  endtask
endmodule

// *** tb/tb_scir_ctrl.sv ***
`timescale 1ns/1ps
module tb_scir_ctrl;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic rd_n, wr_n, ce_n, dc, ab, intack_n, int_oe, chain_out, int_rst, wq_a, wq_b, master_irq_enable, lower_chain_disable;
  logic chain_in = 1'b1;
  logic doe;
  logic [7:0] wd, rdata, v, en_a, en_b;
  logic [3:0] sa = 4'hF; // {ext, tx_empty, special, rx_char}
  logic [3:0] sb = 4'hF;
  logic [31:0] rnd = 32'h4524;
  int error_cnt, num_checks, rst_cyc, n, k, oe_cyc;

  scir_ctrl dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rd_n_i(rd_n), .wr_n_i(wr_n), .ce_n_i(ce_n),
    .dc_i(dc), .ab_i(ab), .intack_n_i(intack_n), .irq_chain_enable_in_i(chain_in),
    .data_i(wd), .data_o(rdata), .data_oe_o(doe), .a_rx_char_i(sa[0]), .a_rx_special_i(sa[1]),
    .a_tx_empty_i(sa[2]), .a_ext_change_i(sa[3]), .b_rx_char_i(sb[0]), .b_rx_special_i(sb[1]),
    .b_tx_empty_i(sb[2]), .b_ext_change_i(sb[3]), .a_rx_pop_o(), .b_rx_pop_o(), .int_n_o(),
    .int_oe_o(int_oe), .irq_chain_enable_out_o(chain_out), .a_wreq_n_o(), .a_wreq_oe_o(wq_a),
    .b_wreq_n_o(), .b_wreq_oe_o(wq_b), .int_rst_o(int_rst));
  scir_host_bfm host_u (.clk_i(clk_i), .data_o(rdata), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .ce_n_o(ce_n), .dc_o(dc), .ab_o(ab), .intack_n_o(intack_n), .wd_o(wd));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (int_rst === 1'b1)
      rst_cyc <= rst_cyc + 1;
    if (doe === 1'b1)
      oe_cyc <= oe_cyc + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [2:0] pend3(input logic [7:0] e, input logic [3:0] s);
    logic rx;
    rx = ((e[4:3] == 2'b01 || e[4:3] == 2'b10) && s[0]) || (e[4:3] != 2'b00 && e[2] && s[1]);
    return {rx, e[1] & s[2], e[0] & s[3]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_run();
    n = 0;
    while (int_rst !== 1'b0 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (int_rst !== 1'b0) begin
      error_cnt++;
      $display("ERROR %0t internal reset stuck", $time);
      wrap_up();
    end
  endtask

  task automatic wr_reg(input logic a, input logic [7:0] p, input logic [7:0] d);
    host_u.access(1'b1, 1'b0, a, p, v);
    host_u.access(1'b1, 1'b0, a, d, v);
  endtask

  task automatic rd_reg(input logic a, input logic [7:0] p);
    host_u.access(1'b1, 1'b0, a, p, v);
    host_u.access(1'b0, 1'b0, a, 8'h00, v);
  endtask

  task automatic set_en(input logic a, input logic [7:0] e);
    wr_reg(a, 8'h01, e);
    if (a)
      en_a = e;
    else
      en_b = e;
  endtask

  task automatic set_mc(input logic [1:0] c, input logic m, input logic d);
    wr_reg(1'b1, 8'h09, {c, 2'b00, m, d, 2'b00});
    master_irq_enable = m;
    lower_chain_disable = d;
    if (c[0])
      en_b = en_b & (c[1] ? 8'h00 : 8'h18);
    if (c[1])
      en_a = en_a & (c[0] ? 8'h00 : 8'h18);
    if (c == 2'b11)
      wait_run();
  endtask

  // No acknowledge is pending here, so no source is in service
  task automatic check_all();
    logic [5:0] p;
    p = {pend3(en_a, sa), pend3(en_b, sb)};
    rd_reg(1'b1, 8'h03);
    cmp_reg(v, {2'b00, p});
    cmp_pin(int_oe, master_irq_enable & chain_in & (|p));
    cmp_pin(chain_out, chain_in & ~lower_chain_disable);
    cmp_pin(wq_a | wq_b, 1'b0);
  endtask

  initial begin
    en_a = 8'h00;
    en_b = 8'h00;
    master_irq_enable = 1'b0;
    lower_chain_disable = 1'b0;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    wait_run();
    host_u.access(1'b0, 1'b0, 1'b1, 8'h00, v);
    cmp_reg(v, {4'h0, sa[3], sa[2], 1'b0, sa[0]});
    cmp_pin(oe_cyc >= 3, 1'b1);
    host_u.access(1'b0, 1'b1, 1'b1, 8'h00, v);
    host_u.access(1'b0, 1'b1, 1'b0, 8'h00, v);
    check_all();
    host_u.access(1'b1, 1'b0, 1'b1, 8'h01, v);
    host_u.access(1'b0, 1'b0, 1'b1, 8'h00, v);
    check_all();
    sa = 4'b0001;
    sb = 4'b0000;
    for (int m = 0; m < 4; m++) begin
      set_en(1'b1, {3'b000, m[1:0], 3'b000});
      rd_reg(1'b1, 8'h01);
      cmp_reg(v, 8'h00);
      check_all();
    end
    sa = 4'b0010;
    set_en(1'b1, 8'h1C);
    check_all();
    for (int i = 0; i < 8; i++) begin
      repeat (32) rnd = lfsr(rnd);
      sa = rnd[3:0];
      sb = rnd[7:4];
      chain_in = rnd[24] | rnd[25];
      set_en(1'b1, {3'b000, rnd[12:8]});
      set_en(1'b0, {3'b000, rnd[20:16]});
      sa[1] = sa[1] & en_a[2];
      sb[1] = sb[1] & en_b[2];
      set_mc(2'b00, rnd[26], rnd[27]);
      check_all();
    end
    chain_in = 1'b1;
    sa = 4'b0100;
    sb = 4'b0101;
    set_en(1'b1, 8'h02);
    set_en(1'b0, 8'h12);
    set_mc(2'b00, 1'b1, 1'b0);
    check_all();
    host_u.ack();
    cmp_pin(int_oe, 1'b0);
    cmp_pin(chain_out, 1'b0);
    host_u.access(1'b1, 1'b0, 1'b1, 8'h38, v);
    check_all();
    for (int c = 1; c < 4; c++) begin
      k = rst_cyc;
      set_mc(c[1:0], 1'b1, 1'b0);
      cmp_pin(rst_cyc - k >= 4, c == 3);
      check_all();
    end
    set_en(1'b1, 8'h02);
    check_all();
    host_u.pin_reset();
    cmp_pin(int_rst, 1'b1);
    wait_run();
    cmp_pin(n >= 4 && n <= 8, 1'b1);
    repeat (4) @(negedge clk_i);
    master_irq_enable = 1'b0;
    en_a = 8'h00;
    en_b = 8'h00;
    host_u.pin_reset();
    host_u.access(1'b1, 1'b0, 1'b1, 8'h01, v);
    check_all();
    set_en(1'b1, 8'h02);
    check_all();
    set_en(1'b1, 8'hC0);
    cmp_pin(wq_a, sa[2]);
    set_en(1'b1, 8'h80);
    cmp_pin(wq_a, ~sa[2]);
    wrap_up();
  end
endmodule

// *** verilog/scir_ctrl.sv ***
`timescale 1ns/1ps
`include "scir_defs.svh"
module scir_ctrl
  import scir_pkg::*;
#(
  parameter int NSRC = 6
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ce_n_i,
  input wire logic dc_i,
  input wire logic ab_i,
  input wire logic intack_n_i,
  input wire logic irq_chain_enable_in_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic a_rx_char_i,
  input wire logic a_rx_special_i,
  input wire logic a_tx_empty_i,
  input wire logic a_ext_change_i,
  input wire logic b_rx_char_i,
  input wire logic b_rx_special_i,
  input wire logic b_tx_empty_i,
  input wire logic b_ext_change_i,
  output logic a_rx_pop_o,
  output logic b_rx_pop_o,
  output logic int_n_o,
  output logic int_oe_o,
  output logic irq_chain_enable_out_o,
  output logic a_wreq_n_o,
  output logic a_wreq_oe_o,
  output logic b_wreq_n_o,
  output logic b_wreq_oe_o,
  output logic int_rst_o
);
  // Synchronised pins
  logic [14:0] pin_async;
  logic [14:0] pin_sync;
  logic [14:0] pin_rst_val;
  logic rd_n_s;
  logic wr_n_s;
  logic ce_n_s;
  logic dc_s;
  logic ab_s;
  logic intack_n_s;
  logic iei_s;
  logic [7:0] data_s;

  // Strobe edge detection
  logic rd_n_q;
  logic wr_n_q;
  logic rd_fall;
  logic wr_fall;

  // Reset control
  scir_rst_state_t rst_state_q;
  scir_rst_state_t rst_state_d;
  logic [2:0] rst_cnt_q;
  logic [2:0] rst_cnt_d;
  logic hw_cond;
  logic full_sw_rst;
  logic rst_int;

  // Access decode
  logic access_ok;
  logic rd_acc;
  logic wr_acc;
  logic ack_rd;
  logic cmd_wr;
  logic cmd_rd;
  logic reg_wr;
  logic data_rd;
  logic [3:0] ptr_q;
  logic [3:0] ptr_d;
  logic [2:0] cmd_code;
  logic ptr_zero;

  // Master control register
  logic [5:0] mc_q;
  logic mc_wr;
  logic [1:0] mc_rst_cmd;
  logic master_irq_enable;
  logic lower_chain_disable;
  logic ch_a_rst;
  logic ch_b_rst;

  // Channel registers and sources
  logic a_se_wr;
  logic b_se_wr;
  logic [7:0] a_en;
  logic [7:0] b_en;
  logic [2:0] a_pend;
  logic [2:0] b_pend;
  logic [2:0] a_ius;
  logic [2:0] b_ius;
  logic a_wreq_act;
  logic b_wreq_act;
  logic [NSRC-1:0] pend_all;
  logic [NSRC-1:0] ius_all;
  logic [NSRC-1:0] ius_set;
  logic [NSRC-1:0] ius_clr;
  logic [NSRC-1:0] ack_pick;
  logic [NSRC-1:0] top_ius;
  logic req_any;
  logic any_ius;
  logic any_pend;

  // Read data
  logic [7:0] rd_mux;
  logic [7:0] status_a;
  logic [7:0] status_b;
  logic [7:0] pend_rd;
  logic [7:0] data_q;
  logic drive_q;

  // Pins cross into this clock through two flops; strobes idle high
  assign pin_async = {data_i, irq_chain_enable_in_i, intack_n_i,
                      ab_i, dc_i, ce_n_i, wr_n_i, rd_n_i};
  assign pin_rst_val = `SCIR_PIN_IDLE;

  scir_sync #(.W(15)) u_pin_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pin_async),
    .rst_val_i(pin_rst_val),
    .sync_o(pin_sync)
  );

  assign rd_n_s = pin_sync[0];
  assign wr_n_s = pin_sync[1];
  assign ce_n_s = pin_sync[2];
  assign dc_s = pin_sync[3];
  assign ab_s = pin_sync[4];
  assign intack_n_s = pin_sync[5];
  assign iei_s = pin_sync[6];
  assign data_s = pin_sync[14:7];

  // Strobe falls mark the start of an access
  assign rd_fall = rd_n_q & ~rd_n_s & wr_n_s;
  assign wr_fall = wr_n_q & ~wr_n_s & rd_n_s;

  // Both strobes low is a reset no matter what chip enable shows
  assign hw_cond = ~rd_n_s & ~wr_n_s;
  assign full_sw_rst = mc_wr & (mc_rst_cmd == `SCIR_RST_FULL);
  assign rst_int = hw_cond | (rst_state_q != SCIR_RS_RUN);
  assign int_rst_o = rst_int;

  always_comb begin
    rst_state_d = rst_state_q;
    rst_cnt_d = rst_cnt_q;
    case (rst_state_q)
      SCIR_RS_RUN: begin
        if (hw_cond) begin
          rst_state_d = SCIR_RS_HOLD;
        end else if (full_sw_rst) begin
          rst_state_d = SCIR_RS_STRETCH;
          rst_cnt_d = `SCIR_RST_STRETCH_CYC;
        end
      end
      SCIR_RS_HOLD: begin
        if (!hw_cond) begin
          rst_state_d = SCIR_RS_STRETCH;
          rst_cnt_d = `SCIR_RST_STRETCH_CYC;
        end
      end
      SCIR_RS_STRETCH: begin
        if (hw_cond) begin
          rst_state_d = SCIR_RS_HOLD;
        end else if (rst_cnt_q == 3'h1) begin
          rst_state_d = SCIR_RS_RUN;
          rst_cnt_d = 3'h0;
        end else begin
          rst_cnt_d = rst_cnt_q - 3'h1;
        end
      end
      default: begin
        rst_state_d = SCIR_RS_RUN;
        rst_cnt_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_state_q <= SCIR_RS_HOLD;
      rst_cnt_q <= 3'h0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      rst_state_q <= rst_state_d;
      rst_cnt_q <= rst_cnt_d;
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
    end
  end

  // Accesses during the stretched reset are dropped
  assign access_ok = ~rst_int & ~ce_n_s;
  assign rd_acc = rd_fall & access_ok & intack_n_s;
  assign wr_acc = wr_fall & access_ok;
  assign ack_rd = rd_fall & ~rst_int & ~intack_n_s;
  assign cmd_rd = rd_acc & ~dc_s;
  assign data_rd = rd_acc & dc_s;
  assign cmd_wr = wr_acc & ~dc_s;
  assign ptr_zero = (ptr_q == `SCIR_PTR_STATUS);
  assign cmd_code = data_s[5:3];
  assign reg_wr = cmd_wr & ~ptr_zero;

  always_comb begin
    ptr_d = ptr_q;
    if (cmd_rd) begin
      ptr_d = 4'h0;
    end else if (cmd_wr && ptr_zero) begin
      ptr_d = {cmd_code == `SCIR_CMD_POINT_HIGH, data_s[2:0]};
    end else if (cmd_wr) begin
      ptr_d = 4'h0;
    end
  end

  // Master control is shared by both channels
  assign mc_wr = reg_wr & (ptr_q == `SCIR_PTR_MASTER);
  assign mc_rst_cmd = data_s[7:6];
  assign ch_a_rst = mc_wr & (mc_rst_cmd == `SCIR_RST_CH_A);
  assign ch_b_rst = mc_wr & (mc_rst_cmd == `SCIR_RST_CH_B);
  assign master_irq_enable = mc_q[`SCIR_MC_MIE];
  assign lower_chain_disable = mc_q[`SCIR_MC_DLC];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr_q <= 4'h0;
      mc_q <= `SCIR_MC_RESET_VAL;
    end else if (hw_cond) begin
      ptr_q <= 4'h0;
      mc_q <= `SCIR_MC_RESET_VAL;
    end else begin
      ptr_q <= ptr_d;
      if (mc_wr) begin
        // Loaded on every write, including one carrying a reset command
        mc_q <= data_s[5:0];
      end
    end
  end

  assign a_se_wr = reg_wr & (ptr_q == `SCIR_PTR_SRC_EN) & ab_s;
  assign b_se_wr = reg_wr & (ptr_q == `SCIR_PTR_SRC_EN) & ~ab_s;

  // Receive data is fetched elsewhere; reset never pops or flushes it
  assign a_rx_pop_o = data_rd & ab_s;
  assign b_rx_pop_o = data_rd & ~ab_s;

  scir_src_chan u_chan_a (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .hw_rst_i(rst_int),
    .chan_rst_i(ch_a_rst),
    .wr_en_i(a_se_wr),
    .wr_data_i(data_s),
    .rx_char_i(a_rx_char_i),
    .rx_special_i(a_rx_special_i),
    .tx_empty_i(a_tx_empty_i),
    .ext_change_i(a_ext_change_i),
    .rx_read_i(a_rx_pop_o),
    .ius_set_i(ius_set[5:3]),
    .ius_clr_i(ius_clr[5:3]),
    .enable_o(a_en),
    .pend_o(a_pend),
    .ius_o(a_ius),
    .wreq_active_o(a_wreq_act)
  );

  scir_src_chan u_chan_b (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .hw_rst_i(rst_int),
    .chan_rst_i(ch_b_rst),
    .wr_en_i(b_se_wr),
    .wr_data_i(data_s),
    .rx_char_i(b_rx_char_i),
    .rx_special_i(b_rx_special_i),
    .tx_empty_i(b_tx_empty_i),
    .ext_change_i(b_ext_change_i),
    .rx_read_i(b_rx_pop_o),
    .ius_set_i(ius_set[2:0]),
    .ius_clr_i(ius_clr[2:0]),
    .enable_o(b_en),
    .pend_o(b_pend),
    .ius_o(b_ius),
    .wreq_active_o(b_wreq_act)
  );

  // Bit 5 is channel A receive, the highest; bit 0 the lowest
  assign pend_all = {a_pend, b_pend};
  assign ius_all = {a_ius, b_ius};

  always_comb begin
    logic above_ius;
    logic taken;
    logic found;
    above_ius = 1'b0;
    taken = 1'b0;
    found = 1'b0;
    req_any = 1'b0;
    ack_pick = '0;
    top_ius = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend_all[i] && !ius_all[i] && !above_ius) begin
        req_any = 1'b1;
      end
      if (pend_all[i] && !above_ius && !taken) begin
        ack_pick[i] = 1'b1;
        taken = 1'b1;
      end
      if (ius_all[i] && !found) begin
        top_ius[i] = 1'b1;
        found = 1'b1;
      end
      above_ius = above_ius | ius_all[i];
    end
  end

  assign any_ius = |ius_all;
  assign any_pend = |pend_all;
  // Acknowledge only reaches us when the chain above lets it through
  assign ius_set = (ack_rd & master_irq_enable & iei_s) ? ack_pick : '0;
  assign ius_clr = (cmd_wr & ptr_zero & (cmd_code == `SCIR_CMD_RESET_IUS)) ? top_ius : '0;

  // Open drain: pin is pulled low only while a source needs service
  assign int_n_o = 1'b0;
  assign int_oe_o = master_irq_enable & iei_s & intack_n_s & req_any & ~rst_int;
  assign irq_chain_enable_out_o = iei_s & ~lower_chain_disable & ~any_ius &
                                  ~(~intack_n_s & master_irq_enable & any_pend);

  assign a_wreq_n_o = 1'b0;
  assign b_wreq_n_o = 1'b0;
  assign a_wreq_oe_o = a_wreq_act & ~rst_int;
  assign b_wreq_oe_o = b_wreq_act & ~rst_int;

  // Read-back views
  assign status_a = {4'h0, a_ext_change_i, a_tx_empty_i, 1'b0, a_rx_char_i};
  assign status_b = {4'h0, b_ext_change_i, b_tx_empty_i, 1'b0, b_rx_char_i};
  assign pend_rd = ab_s ? {2'b00, pend_all} : 8'h00;

  always_comb begin
    case (ptr_q)
      `SCIR_PTR_STATUS: rd_mux = ab_s ? status_a : status_b;
      `SCIR_PTR_PEND: rd_mux = pend_rd;
      default: rd_mux = 8'h00;
    endcase
  end

  // Enable registers are write-only and read back as zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      if (cmd_rd) begin
        data_q <= rd_mux;
      end else if (data_rd) begin
        data_q <= 8'h00;
      end
      drive_q <= (drive_q | rd_acc) & ~rd_n_s & ~rst_int;
    end
  end

  assign data_o = data_q;
  assign data_oe_o = drive_q;
endmodule

// *** verilog/scir_defs.svh ***
// What this block does
// - Both strobes low means hardware reset
// - Internal reset stretched five cycles after release
// - Host accesses ignored during internal reset
// - Hardware reset leaves receive FIFO untouched
// - Three software reset commands in master control
// - Channel reset clears some own-channel bits
// - Full software reset acts as hardware reset but loads master control from the written byte
// - Command read forces register pointer to zero
// - Master control bits cleared only by hardware reset
// - Polling mode when both enables are zero
// - Interrupt output low only when service needed
// - Three sources per channel, six in total
// - Fixed priority, channel A receive highest
// - Each source has enable, pending, in-service
// - Lower chain disable bit blocks downstream devices
// - Disabled source never requests an interrupt
// - Source enable bits zero, one, two
// - Bits four, three select receive mode
// - Pending never set while source disabled
// - Lower chain disable drives chain output low
`ifndef SCIR_DEFS_SVH
`define SCIR_DEFS_SVH

`define SCIR_RST_STRETCH_CYC 3'd4
// Strobes, chip enable and acknowledge idle high
`define SCIR_PIN_IDLE 15'h0027
`define SCIR_PTR_STATUS 4'h0
`define SCIR_PTR_SRC_EN 4'h1
`define SCIR_PTR_PEND 4'h3
`define SCIR_PTR_MASTER 4'h9
`define SCIR_CMD_POINT_HIGH 3'h1
`define SCIR_CMD_RESET_IUS 3'h7
`define SCIR_RST_NONE 2'h0
`define SCIR_RST_CH_B 2'h1
`define SCIR_RST_CH_A 2'h2
`define SCIR_RST_FULL 2'h3
`define SCIR_MC_RESET_VAL 6'h00
`define SCIR_SE_RESET_VAL 8'h00
`define SCIR_SE_CH_RST_KEEP 8'h18
`define SCIR_MC_DLC 2
`define SCIR_MC_MIE 3
`define SCIR_SE_EXT_EN 0
`define SCIR_SE_TX_EN 1
`define SCIR_SE_SPC_EN 2
`define SCIR_SE_RXM_LO 3
`define SCIR_SE_RXM_HI 4
`define SCIR_SE_WR_DIR 5
`define SCIR_SE_WR_FUNC 6
`define SCIR_SE_WR_EN 7

`endif

// *** verilog/scir_pkg.sv ***
package scir_pkg;
  typedef enum logic [1:0] {
    SCIR_RXM_OFF,
    SCIR_RXM_FIRST,
    SCIR_RXM_ALL,
    SCIR_RXM_SPECIAL
  } scir_rx_mode_t;

  typedef enum logic [1:0] {
    SCIR_RS_RUN,
    SCIR_RS_HOLD,
    SCIR_RS_STRETCH
  } scir_rst_state_t;
endpackage

// *** verilog/scir_src_chan.sv ***
`timescale 1ns/1ps
`include "scir_defs.svh"
module scir_src_chan
  import scir_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic hw_rst_i,
  input wire logic chan_rst_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rx_char_i,
  input wire logic rx_special_i,
  input wire logic tx_empty_i,
  input wire logic ext_change_i,
  input wire logic rx_read_i,
  input wire logic [2:0] ius_set_i,
  input wire logic [2:0] ius_clr_i,
  output logic [7:0] enable_o,
  output logic [2:0] pend_o,
  output logic [2:0] ius_o,
  output logic wreq_active_o
);
  logic [7:0] en_q;
  logic [2:0] ius_q;
  logic first_q;
  logic first_d;
  scir_rx_mode_t rx_mode;
  logic rx_char_ip;
  logic rx_spc_ip;
  logic rx_ip;
  logic tx_ip;
  logic ext_ip;
  logic wr_rx_sel;

  assign rx_mode = scir_rx_mode_t'(en_q[`SCIR_SE_RXM_HI:`SCIR_SE_RXM_LO]);
  assign rx_char_ip = rx_char_i & ((rx_mode == SCIR_RXM_ALL) |
                      ((rx_mode == SCIR_RXM_FIRST) & first_q));
  // Special conditions only count when the special enable is also set
  assign rx_spc_ip = rx_special_i & en_q[`SCIR_SE_SPC_EN] & (rx_mode != SCIR_RXM_OFF);
  assign rx_ip = rx_char_ip | rx_spc_ip;
  assign tx_ip = tx_empty_i & en_q[`SCIR_SE_TX_EN];
  assign ext_ip = ext_change_i & en_q[`SCIR_SE_EXT_EN];
  assign pend_o = {rx_ip, tx_ip, ext_ip};
  assign enable_o = en_q;
  assign ius_o = ius_q;

  // First-character mode re-arms when the mode is written again
  assign first_d = wr_en_i ? 1'b1 : (first_q & ~(rx_read_i & rx_char_i));

  assign wr_rx_sel = en_q[`SCIR_SE_WR_DIR];
  assign wreq_active_o = en_q[`SCIR_SE_WR_EN] & (en_q[`SCIR_SE_WR_FUNC] ?
                         (wr_rx_sel ? rx_char_i : tx_empty_i) :
                         (wr_rx_sel ? ~rx_char_i : ~tx_empty_i));

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q <= `SCIR_SE_RESET_VAL;
      ius_q <= 3'h0;
      first_q <= 1'b1;
    end else if (hw_rst_i) begin
      en_q <= `SCIR_SE_RESET_VAL;
      ius_q <= 3'h0;
      first_q <= 1'b1;
    end else if (chan_rst_i) begin
      en_q <= en_q & `SCIR_SE_CH_RST_KEEP;
      ius_q <= 3'h0;
      first_q <= 1'b1;
    end else begin
      if (wr_en_i) begin
        en_q <= wr_data_i;
      end
      ius_q <= (ius_q & ~ius_clr_i) | ius_set_i;
      first_q <= first_d;
    end
  end
endmodule

// *** verilog/scir_sync.sv ***
`timescale 1ns/1ps
module scir_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic init_q;

  // Reset value is loaded by a clocked step, never by the async reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      init_q <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_q <= init_q ? rst_val_i : meta_q;
      init_q <= 1'b0;
    end
  end

  assign sync_o = sync_q;
endmodule
